// ==== design/ffm_defines.svh ====
// Bit positions, limits and counts for the fault flag monitor
`ifndef FFM_DEFINES_SVH
`define FFM_DEFINES_SVH
// ==========================================
// Fault status word bits
`define FFM_ERR_W 16
`define FFM_ERR_SUPPLY_DIP 0
`define FFM_ERR_FIELD_LOW 1
`define FFM_ERR_OSC_MISMATCH 2
`define FFM_ERR_NVM_FATAL 3
`define FFM_ERR_PLL_UNLOCKED 4
`define FFM_ERR_PATH_COMPARE 5
`define FFM_ERR_POWER_LOSS 6
`define FFM_ERR_QUAD_SKIP 7
`define FFM_ERR_REG_DRIFT 8
`define FFM_ERR_AVG_SPAN 9
// Power loss shows after every reset
`define FFM_ERR_RESET 16'h0040
// ==========================================
// Caution status word bits
`define FFM_WARN_W 16
`define FFM_WARN_FIELD_HIGH 0
`define FFM_WARN_TEMP_LIMIT 1
`define FFM_WARN_NVM_CORRECTED 2
`define FFM_WARN_TURN_SAT 3
`define FFM_WARN_LP_JUMP 4
`define FFM_WARN_FRAME_FORMAT 5
`define FFM_WARN_CRC 6
`define FFM_WARN_RESET 16'h0000
// ==========================================
// Position result word layout
`define FFM_POS_GENERAL_ERR 15
`define FFM_POS_SUPPLY_LOW 14
// ==========================================
// Thresholds and limits
`define FFM_FIELD_HI_STEP_SHIFT 5
`define FFM_FIELD_LO_STEP_SHIFT 4
`define FFM_TEMP_MIN_C (-60)
`define FFM_TEMP_MAX_C 180
`define FFM_TURN_LIMIT 256
// 135 degrees at 4096 codes per turn
`define FFM_LP_JUMP_DEG 135
`define FFM_LP_JUMP_CODES ((`FFM_LP_JUMP_DEG * 4096) / 360)
`define FFM_SCLK_SHORT 16
`define FFM_SCLK_LONG 20
`define FFM_LEVEL_COUNT 6
`endif

// ==== design/ffm_pkg.sv ====
// Types shared by the fault flag monitor
package ffm_pkg;
  // ==========================================
  // Monitor levels arriving from the analog domain
  typedef struct packed {
    logic supply_dip;
    logic reg_drift;
    logic osc_mismatch;
    logic pll_unlocked;
    logic path_mismatch;
    logic path_saturated;
  } ffm_levels_t;
  // ==========================================
  // One received serial frame, reported by the frame logic
  typedef struct packed {
    logic done;
    logic [5:0] sclk_count;
    logic first_mosi;
    logic crc_ok;
  } ffm_frame_t;
  typedef enum logic [1:0] {FFM_LP_ASLEEP, FFM_LP_WAKE, FFM_LP_HOLD} ffm_lp_state_t;
endpackage

// ==== design/ffm_sync.sv ====
// Three-stage synchroniser with agreement filter for monitor levels
`timescale 1ns/100ps
`default_nettype none
module ffm_sync #(
  parameter int W = 6
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [W-1:0] D,
  output logic [W-1:0] Q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  wire [W-1:0] agree = ~(s2 ^ s3);
  wire [W-1:0] next_q = (agree & s3) | (~agree & Q);
  // A level counts only once stages two and three agree
  always_ff @(posedge CLK) begin
    if (RESET) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      Q <= '0;
    end else begin
      s1 <= D;
      s2 <= s1;
      s3 <= s2;
      Q <= next_q;
    end
  end
endmodule
`default_nettype wire

// ==== design/ffm_monitor.sv ====
// Fault and caution flag collection for the angle sensor
//
// How it works
// - Supply dip sets fault bit and supply low
// - Field above high threshold sets caution flag
// - Field below low threshold sets fault flag
// - Temperature outside -60..180 sets caution flag
// - Oscillator cross-check mismatch sets fault flag
// - Single-bit memory error corrected and flagged
// - Multi-bit memory error sets fatal flag
// - Backup path mismatch or PLL unlock flagged
// - Path saturation reported as path failure
// - Power loss flag set after every reset
// - Skipped quadrature state sets skip flag
// - Regulator drift sets fault and supply low
// - Turn count saturating beyond 256 flagged
// - Low-power travel above 135 degrees flagged
// - Stay awake while travel exceeds hold angle
// - Averaging over three quadrants sets flag
// - Bad clock count or MOSI start flagged
// - Enabled long frames need valid check code
// - Any unmasked set flag raises general error summary
// - Masked flags do not drive general summary
// - All flag words are readable outputs
`include "ffm_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module ffm_monitor
  import ffm_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire ffm_levels_t MONITOR_LEVELS,
  input wire logic [11:0] FIELD_GAUSS,
  input wire logic [5:0] FIELD_HIGH_CODE,
  input wire logic [5:0] FIELD_LOW_CODE,
  input wire logic signed [9:0] TEMP_C,
  input wire logic NVM_READ,
  input wire logic [23:0] NVM_RAW,
  input wire logic NVM_SINGLE_ERR,
  input wire logic [4:0] NVM_ERR_POS,
  input wire logic NVM_MULTI_ERR,
  input wire logic [1:0] QUAD_STATE,
  input wire logic TURN_STEP,
  input wire logic TURN_UP,
  input wire logic TURN_CLEAR,
  input wire logic SLEEP_CYCLE_MODE,
  input wire logic WAKE_SAMPLE,
  input wire logic [10:0] WAKE_HOLD_ANGLE,
  input wire logic AVG_SAMPLE,
  input wire logic AVG_PERIOD_END,
  input wire logic [11:0] ANGLE,
  input wire ffm_frame_t FRAME,
  input wire logic FRAME_LONG,
  input wire logic CRC_CHECK_ENABLE,
  input wire logic [15:0] ERR_MASK,
  input wire logic [15:0] WARN_MASK,
  input wire logic [15:0] ERR_CLEAR,
  input wire logic [15:0] WARN_CLEAR,
  output logic [15:0] ERR_WORD,
  output logic [15:0] WARN_WORD,
  output logic [15:0] POSITION_RESULT_WORD,
  output logic [23:0] NVM_DATA,
  output logic NVM_DATA_VALID,
  output logic signed [9:0] TURN_COUNT,
  output logic STAY_AWAKE
);
  // ==========================================
  // Helper functions
  // Shortest circular distance between two 12-bit angles
  function automatic logic [11:0] angle_dist(input logic [11:0] a, input logic [11:0] b);
    logic [11:0] d;
    d = a - b;
    angle_dist = d[11] ? 12'(-d) : d;
  endfunction

  function automatic logic [2:0] count4(input logic [3:0] v);
    count4 = 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]);
  endfunction

  // ==========================================
  // Synchronised analog monitor levels
  // Levels reach the flags five edges after the pin moves
  ffm_levels_t lvl;
  ffm_sync #(.W(`FFM_LEVEL_COUNT)) u_sync (
    .CLK(CLK),
    .RESET(RESET),
    .D(MONITOR_LEVELS),
    .Q(lvl)
  );

  // ==========================================
  // Field and temperature comparisons
  wire [10:0] field_hi_limit = {FIELD_HIGH_CODE, 5'h00};
  wire [9:0] field_lo_limit = {FIELD_LOW_CODE, 4'h0};
  // A zero code disables the check
  wire field_high = (FIELD_HIGH_CODE != 6'h00) && (FIELD_GAUSS > {1'b0, field_hi_limit});
  wire field_low = (FIELD_LOW_CODE != 6'h00) && (FIELD_GAUSS < {2'b00, field_lo_limit});
  wire temp_limit = (TEMP_C < 10'(`FFM_TEMP_MIN_C)) || (TEMP_C > 10'(`FFM_TEMP_MAX_C));

  // ==========================================
  // Memory error correction
  wire [23:0] flip_mask = 24'h000001 << NVM_ERR_POS;
  wire [23:0] next_nvm_data = NVM_SINGLE_ERR ? (NVM_RAW ^ flip_mask) : NVM_RAW;
  wire nvm_corrected = NVM_READ && NVM_SINGLE_ERR && !NVM_MULTI_ERR;
  wire nvm_fatal = NVM_READ && NVM_MULTI_ERR;

  // ==========================================
  // Quadrature sequence tracking
  logic [1:0] quad_prev;
  wire [1:0] quad_diff = QUAD_STATE ^ quad_prev;
  // Both lines moving at once means a state was skipped
  wire quad_skip = (quad_diff == 2'h3);

  // ==========================================
  // Turns counter, clamped at the limit
  // Down steps clamp at the same limit; a clear wins over a step
  wire turn_at_top = (TURN_COUNT == 10'(`FFM_TURN_LIMIT));
  wire turn_at_bot = (TURN_COUNT == -10'(`FFM_TURN_LIMIT));
  wire turn_sat = TURN_STEP && (TURN_UP ? turn_at_top : turn_at_bot);
  wire signed [9:0] next_turn = TURN_CLEAR ? 10'sh000 :
    (TURN_STEP && !turn_sat) ? (TURN_UP ? TURN_COUNT + 10'sh001 : TURN_COUNT - 10'sh001) :
    TURN_COUNT;

  // ==========================================
  // Low-power wake travel
  ffm_lp_state_t lp_state;
  ffm_lp_state_t next_lp_state;
  logic [11:0] wake_prev;
  wire [11:0] wake_travel = angle_dist(ANGLE, wake_prev);
  wire wake_check = SLEEP_CYCLE_MODE && WAKE_SAMPLE && (lp_state != FFM_LP_ASLEEP);
  wire lp_jump = wake_check && (wake_travel > 12'(`FFM_LP_JUMP_CODES));
  wire wake_fast = wake_travel > {1'b0, WAKE_HOLD_ANGLE};

  always_comb begin
    next_lp_state = lp_state;
    unique case (lp_state)
      FFM_LP_ASLEEP: begin
        if (SLEEP_CYCLE_MODE && WAKE_SAMPLE) begin
          next_lp_state = FFM_LP_WAKE;
        end
      end
      FFM_LP_WAKE: begin
        if (!SLEEP_CYCLE_MODE) begin
          next_lp_state = FFM_LP_ASLEEP;
        end else if (WAKE_SAMPLE) begin
          next_lp_state = wake_fast ? FFM_LP_HOLD : FFM_LP_WAKE;
        end
      end
      FFM_LP_HOLD: begin
        // A slow sample or leaving sleep cycle mode drops the hold back to the wake state
        if (!SLEEP_CYCLE_MODE || (WAKE_SAMPLE && !wake_fast)) begin
          next_lp_state = FFM_LP_WAKE;
        end
      end
    endcase
  end

  // ==========================================
  // Averaging quadrant span
  logic [3:0] quad_seen;
  wire [3:0] quad_hit = AVG_SAMPLE ? (4'h1 << ANGLE[11:10]) : 4'h0;
  wire [3:0] quad_now = quad_seen | quad_hit;
  wire avg_span = AVG_PERIOD_END && (count4(quad_now) > 3'h2);
  wire [3:0] next_quad_seen = AVG_PERIOD_END ? 4'h0 : quad_now;

  // ==========================================
  // Serial frame checks
  wire sclk_bad = (FRAME.sclk_count != 6'(`FFM_SCLK_SHORT)) &&
    (FRAME.sclk_count != 6'(`FFM_SCLK_LONG));
  wire frame_format = FRAME.done && (sclk_bad || FRAME.first_mosi);
  // Short frames carry no check code, so only long ones are tested
  wire crc_fail = FRAME.done && FRAME_LONG && CRC_CHECK_ENABLE && !FRAME.crc_ok;

  // ==========================================
  // Flag collection
  logic [15:0] err_set;
  logic [15:0] warn_set;
  always_comb begin
    err_set = 16'h0000;
    warn_set = 16'h0000;
    err_set[`FFM_ERR_SUPPLY_DIP] = lvl.supply_dip;
    err_set[`FFM_ERR_FIELD_LOW] = field_low;
    err_set[`FFM_ERR_OSC_MISMATCH] = lvl.osc_mismatch;
    err_set[`FFM_ERR_NVM_FATAL] = nvm_fatal;
    err_set[`FFM_ERR_PLL_UNLOCKED] = lvl.pll_unlocked;
    err_set[`FFM_ERR_PATH_COMPARE] = lvl.path_mismatch | lvl.path_saturated;
    err_set[`FFM_ERR_QUAD_SKIP] = quad_skip;
    err_set[`FFM_ERR_REG_DRIFT] = lvl.reg_drift;
    err_set[`FFM_ERR_AVG_SPAN] = avg_span;
    warn_set[`FFM_WARN_FIELD_HIGH] = field_high;
    warn_set[`FFM_WARN_TEMP_LIMIT] = temp_limit;
    warn_set[`FFM_WARN_NVM_CORRECTED] = nvm_corrected;
    warn_set[`FFM_WARN_TURN_SAT] = turn_sat;
    warn_set[`FFM_WARN_LP_JUMP] = lp_jump;
    warn_set[`FFM_WARN_FRAME_FORMAT] = frame_format;
    warn_set[`FFM_WARN_CRC] = crc_fail;
  end

  // A new event beats a clear in the same cycle
  wire [15:0] next_err = (ERR_WORD & ~ERR_CLEAR) | err_set;
  wire [15:0] next_warn = (WARN_WORD & ~WARN_CLEAR) | warn_set;
  wire next_general = |(next_err & ~ERR_MASK) || |(next_warn & ~WARN_MASK);
  wire [15:0] supply_low_bits = (16'h0001 << `FFM_ERR_SUPPLY_DIP) |
    (16'h0001 << `FFM_ERR_REG_DRIFT);
  wire next_supply_low = |(next_err & supply_low_bits & ~ERR_MASK);
  wire [15:0] next_pos = {next_general, next_supply_low, 2'b00, ANGLE};

  // ==========================================
  // Registers
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ERR_WORD <= `FFM_ERR_RESET;
      WARN_WORD <= `FFM_WARN_RESET;
      POSITION_RESULT_WORD <= 16'h8000;
    end else begin
      ERR_WORD <= next_err;
      WARN_WORD <= next_warn;
      POSITION_RESULT_WORD <= next_pos;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      NVM_DATA <= 24'h000000;
      NVM_DATA_VALID <= 1'b0;
      TURN_COUNT <= 10'sh000;
      STAY_AWAKE <= 1'b0;
      lp_state <= FFM_LP_ASLEEP;
    end else begin
      NVM_DATA <= NVM_READ ? next_nvm_data : NVM_DATA;
      NVM_DATA_VALID <= NVM_READ;
      TURN_COUNT <= next_turn;
      STAY_AWAKE <= (next_lp_state == FFM_LP_HOLD);
      lp_state <= next_lp_state;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      quad_prev <= 2'h0;
      wake_prev <= 12'h000;
      quad_seen <= 4'h0;
    end else begin
      quad_prev <= QUAD_STATE;
      wake_prev <= WAKE_SAMPLE ? ANGLE : wake_prev;
      quad_seen <= next_quad_seen;
    end
  end

  // ==========================================
  // Assertions
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  AST_SUPPLY_DIP: assert property (lvl.supply_dip |=> ERR_WORD[`FFM_ERR_SUPPLY_DIP] &&
    (POSITION_RESULT_WORD[`FFM_POS_SUPPLY_LOW] || $past(ERR_MASK[`FFM_ERR_SUPPLY_DIP])))
    else $error("Supply dip not reported");
  AST_FIELD_HIGH: assert property ((FIELD_HIGH_CODE == 6'h01 && FIELD_GAUSS == 12'd33)
    |=> WARN_WORD[`FFM_WARN_FIELD_HIGH])
    else $error("Field high not flagged above 32 G");
  AST_FIELD_LOW_OFF: assert property ((FIELD_LOW_CODE == 6'h00) |-> !field_low)
    else $error("Disabled low field check fired");
  AST_TEMP: assert property ((TEMP_C == -10'sd61 || TEMP_C == 10'sd181)
    |=> WARN_WORD[`FFM_WARN_TEMP_LIMIT])
    else $error("Temperature limit missed");
  AST_NVM_FIX: assert property (nvm_corrected |=>
    NVM_DATA == ($past(NVM_RAW) ^ (24'h000001 << $past(NVM_ERR_POS))) &&
    WARN_WORD[`FFM_WARN_NVM_CORRECTED])
    else $error("Memory word not corrected");
  AST_NVM_FATAL: assert property (nvm_fatal |=> ERR_WORD[`FFM_ERR_NVM_FATAL])
    else $error("Multi-bit error not flagged");
  AST_PATH: assert property ((lvl.path_saturated || lvl.path_mismatch)
    |=> ERR_WORD[`FFM_ERR_PATH_COMPARE])
    else $error("Path failure not flagged");
  AST_QUAD: assert property (($past(QUAD_STATE) == 2'h0 && QUAD_STATE == 2'h3)
    |=> ERR_WORD[`FFM_ERR_QUAD_SKIP])
    else $error("Quadrature skip missed");
  AST_TURN_CLAMP: assert property ((TURN_COUNT <= 10'sd256) && (TURN_COUNT >= -10'sd256))
    else $error("Turn count beyond limit");
  AST_LP_JUMP: assert property ((wake_check && wake_travel == 12'd1537)
    |=> WARN_WORD[`FFM_WARN_LP_JUMP])
    else $error("Low-power jump missed");
  AST_HOLD: assert property ((SLEEP_CYCLE_MODE && lp_state != FFM_LP_ASLEEP && WAKE_SAMPLE &&
    wake_fast) |=> STAY_AWAKE[*2] or ##1 !SLEEP_CYCLE_MODE or ##1 WAKE_SAMPLE)
    else $error("Wake hold released early");
  AST_AVG: assert property ((AVG_PERIOD_END && count4(quad_now) == 3'h3)
    |=> ERR_WORD[`FFM_ERR_AVG_SPAN] && quad_seen == 4'h0)
    else $error("Averaging span not flagged");
  AST_FRAME: assert property ((FRAME.done && FRAME.first_mosi)
    |=> WARN_WORD[`FFM_WARN_FRAME_FORMAT])
    else $error("Frame format error missed");
  AST_CRC: assert property ((FRAME.done && !FRAME_LONG) |-> !crc_fail)
    else $error("Check code tested on short frame");
  AST_GENERAL: assert property (POSITION_RESULT_WORD[`FFM_POS_GENERAL_ERR] ==
    (|(ERR_WORD & ~$past(ERR_MASK)) || |(WARN_WORD & ~$past(WARN_MASK))))
    else $error("General summary disagrees with flags");
  AST_STICKY: assert property ((ERR_WORD[`FFM_ERR_OSC_MISMATCH] &&
    !ERR_CLEAR[`FFM_ERR_OSC_MISMATCH]) |=> ERR_WORD[`FFM_ERR_OSC_MISMATCH])
    else $error("Flag dropped without clear");
  AST_SET_WINS: assert property ((lvl.reg_drift && ERR_CLEAR[`FFM_ERR_REG_DRIFT])
    |=> ERR_WORD[`FFM_ERR_REG_DRIFT])
    else $error("Clear beat a new event");

  // ==========================================
  // Flag set, summary, valid and hold checks, one cycle after the cause
  AST_FIELD_LOW: assert property ((FIELD_LOW_CODE == 6'h01 && FIELD_GAUSS == 12'd15)
    |=> ERR_WORD[`FFM_ERR_FIELD_LOW])
    else $error("Field low not flagged below 16 G");
  AST_OSC: assert property (lvl.osc_mismatch |=> ERR_WORD[`FFM_ERR_OSC_MISMATCH])
    else $error("Oscillator mismatch not flagged");
  AST_PLL: assert property (lvl.pll_unlocked |=> ERR_WORD[`FFM_ERR_PLL_UNLOCKED])
    else $error("PLL unlock not flagged");
  AST_DRIFT: assert property (lvl.reg_drift |=> ERR_WORD[`FFM_ERR_REG_DRIFT] &&
    (POSITION_RESULT_WORD[`FFM_POS_SUPPLY_LOW] || $past(ERR_MASK[`FFM_ERR_REG_DRIFT])))
    else $error("Regulator drift not reported");
  AST_TURN_SAT: assert property ((turn_sat && !TURN_CLEAR)
    |=> WARN_WORD[`FFM_WARN_TURN_SAT] && TURN_COUNT == $past(TURN_COUNT))
    else $error("Saturated turn count moved or unflagged");
  AST_SCLK: assert property ((FRAME.done && sclk_bad)
    |=> WARN_WORD[`FFM_WARN_FRAME_FORMAT])
    else $error("Bad clock count not flagged");
  AST_CRC_SET: assert property (crc_fail |=> WARN_WORD[`FFM_WARN_CRC])
    else $error("Check code mismatch not flagged");
  AST_MASKED: assert property ((&ERR_MASK && &WARN_MASK) |=>
    !POSITION_RESULT_WORD[`FFM_POS_GENERAL_ERR])
    else $error("Masked flags drove general summary");
  AST_NVM_VALID: assert property (NVM_READ |=> NVM_DATA_VALID)
    else $error("Memory word not marked valid");
  AST_HOLD_END: assert property ((lp_state == FFM_LP_HOLD && SLEEP_CYCLE_MODE &&
    WAKE_SAMPLE && !wake_fast) |=> !STAY_AWAKE)
    else $error("Wake hold kept after slow sample");
  AST_AVG_ALL: assert property ((AVG_PERIOD_END && count4(quad_now) == 3'h4)
    |=> ERR_WORD[`FFM_ERR_AVG_SPAN])
    else $error("Four-quadrant span not flagged");

  COV_HOLD: cover property (lp_state == FFM_LP_HOLD ##1 lp_state == FFM_LP_WAKE);
  COV_TURN_SAT: cover property (turn_sat);
  COV_CRC: cover property (crc_fail);
  COV_AVG: cover property (avg_span);
  COV_CLEAR: cover property (ERR_WORD[`FFM_ERR_POWER_LOSS] ##1 !ERR_WORD[`FFM_ERR_POWER_LOSS]);
endmodule
`default_nettype wire

// ==== test/ffm_host.sv ====
// Host model that reads the flag words and clears what it has read
`timescale 1ns/100ps
`default_nettype none
module ffm_host (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CLEAR_REQ,
  input wire logic [15:0] ERR_WORD,
  input wire logic [15:0] WARN_WORD,
  output logic [15:0] ERR_CLEAR,
  output logic [15:0] WARN_CLEAR
);
  // ==========
  // Clear only bits seen set, so a flag raised after the read survives
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ERR_CLEAR <= 16'h0000;
      WARN_CLEAR <= 16'h0000;
    end else begin
      ERR_CLEAR <= CLEAR_REQ ? ERR_WORD : 16'h0000;
      WARN_CLEAR <= CLEAR_REQ ? WARN_WORD : 16'h0000;
    end
  end
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
// Self-checking bench for the fault flag monitor
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import ffm_pkg::*;
  logic clk = 1'h0, rst = 1'h1, rd = 1'h0, s_err = 1'h0, m_err = 1'h0;
  logic step = 1'h0, tclr = 1'h0, tup = 1'h1, slp = 1'h0, wake = 1'h0, asmp = 1'h0;
  logic aend = 1'h0, flong = 1'h0, crc_en = 1'h0, creq = 1'h0, nvv, stay;
  ffm_levels_t lv = '0;
  ffm_frame_t fr = '0;
  logic [11:0] gauss = 12'h014, angle_in = 12'h000;
  logic signed [9:0] temp = 10'sh019, tcnt;
  logic [23:0] raw = 24'h000000, nvd;
  logic [15:0] emask = 16'h0000, wmask = 16'h0000, eclr, wclr, err, warn, pos;
  logic [1:0] quad = 2'h0;
  int fail_count = 0, total_checks = 0;
  int tg[8] = '{32, 33, 16, 15, 20, 20, 20, 20};
  int tt[8] = '{25, 25, 25, 25, -60, -61, 180, 181};
  int te[8] = '{0, 0, 0, 2, 0, 0, 0, 0};
  int tw[8] = '{0, 1, 0, 0, 0, 2, 0, 2};
  int eb[6] = '{0, 8, 2, 4, 5, 5};
  int fc[6] = '{16, 20, 17, 16, 20, 20};
  int fb[6] = '{3, 7, 3, 11, 5, 4};
  int fw[6] = '{0, 0, 32, 32, 64, 0};

  ffm_monitor DUT (
    .CLK(clk), .RESET(rst), .MONITOR_LEVELS(lv), .FIELD_GAUSS(gauss),
    .FIELD_HIGH_CODE(6'h01), .FIELD_LOW_CODE(6'h01), .TEMP_C(temp),
    .NVM_READ(rd), .NVM_RAW(raw), .NVM_SINGLE_ERR(s_err), .NVM_ERR_POS(5'h03),
    .NVM_MULTI_ERR(m_err), .QUAD_STATE(quad), .TURN_STEP(step), .TURN_UP(tup),
    .TURN_CLEAR(tclr), .SLEEP_CYCLE_MODE(slp), .WAKE_SAMPLE(wake),
    .WAKE_HOLD_ANGLE(11'h29F), .AVG_SAMPLE(asmp), .AVG_PERIOD_END(aend),
    .ANGLE(angle_in), .FRAME(fr), .FRAME_LONG(flong), .CRC_CHECK_ENABLE(crc_en),
    .ERR_MASK(emask), .WARN_MASK(wmask), .ERR_CLEAR(eclr), .WARN_CLEAR(wclr),
    .ERR_WORD(err), .WARN_WORD(warn), .POSITION_RESULT_WORD(pos), .NVM_DATA(nvd),
    .NVM_DATA_VALID(nvv), .TURN_COUNT(tcnt), .STAY_AWAKE(stay)
  );
  ffm_host HOST (
    .CLK(clk), .RESET(rst), .CLEAR_REQ(creq), .ERR_WORD(err),
    .WARN_WORD(warn), .ERR_CLEAR(eclr), .WARN_CLEAR(wclr)
  );

  initial begin
    forever #10 clk = ~clk;
  end
  // ==========
  // Shared tasks
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic go(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic clr();
    @(posedge clk) creq <= 1'h1;
    @(posedge clk) creq <= 1'h0;
    go(2);
    chk("err_clr", 24'h0, {8'h00, err});
    chk("warn_clr", 24'h0, {8'h00, warn});
  endtask
  // Flags must still stand here although their cause has gone
  task automatic expf(input string nm, input logic [15:0] e, input logic [15:0] w);
    chk({nm, "_err"}, {8'h00, e}, {8'h00, err});
    chk({nm, "_warn"}, {8'h00, w}, {8'h00, warn});
    chk({nm, "_sum"}, {23'h0, |{e, w}}, {23'h0, pos[15]});
    clr();
  endtask
  task automatic wk(input logic [11:0] a, input logic e);
    @(posedge clk) begin
      wake <= 1'h1;
      angle_in <= a;
    end
    @(posedge clk) wake <= 1'h0;
    #1 chk("stay", {23'h0, e}, {23'h0, stay});
  endtask
  task automatic avp(input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge clk) begin
        asmp <= 1'h1;
        angle_in <= 12'(k * 1024);
        aend <= (k == n - 1);
      end
    end
    @(posedge clk) begin
      asmp <= 1'h0;
      aend <= 1'h0;
    end
    #1;
  endtask
  task automatic test_done();
    if (fail_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    fail_count++;
    test_done();
  end
  // ==========
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    go(1);
    chk("err_rst", 24'h000040, {8'h00, err});
    chk("warn_rst", 24'h0, {8'h00, warn});
    chk("pos_rst", 24'h008000, {8'h00, pos});
    @(posedge clk) emask <= 16'hFFFF;
    wmask <= 16'hFFFF;
    go(2);
    chk("masked", 24'h0, {23'h0, pos[15]});
    @(posedge clk) emask <= 16'h0000;
    wmask <= 16'h0000;
    go(2);
    expf("pwr", 16'h0040, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk) gauss <= 12'(tg[i]);
      temp <= 10'(tt[i]);
      go(2);
      @(posedge clk) gauss <= 12'h014;
      temp <= 10'sh019;
      go(2);
      expf("lvl", 16'(te[i]), 16'(tw[i]));
    end
    for (int i = 0; i < 6; i++) begin
      @(posedge clk) lv <= ffm_levels_t'(6'h20 >> i);
      go(6);
      chk("sup_low", {23'h0, i < 2}, {23'h0, pos[14]});
      @(posedge clk) lv <= '0;
      go(6);
      expf("mon", 16'h0001 << eb[i], 16'h0000);
    end
    @(posedge clk) rd <= 1'h1;
    s_err <= 1'h1;
    raw <= 24'hA5A5A5;
    @(posedge clk) rd <= 1'h0;
    s_err <= 1'h0;
    #1 chk("nvm_ok", 24'h1, {23'h0, nvv});
    chk("nvm_data", 24'hA5A5AD, nvd);
    expf("nvm_fix", 16'h0000, 16'h0004);
    @(posedge clk) rd <= 1'h1;
    s_err <= 1'h1;
    m_err <= 1'h1;
    @(posedge clk) rd <= 1'h0;
    s_err <= 1'h0;
    m_err <= 1'h0;
    #1 expf("nvm_bad", 16'h0008, 16'h0000);
    @(posedge clk) quad <= 2'h1;
    go(2);
    chk("quad_ok", 24'h0, {8'h00, err});
    @(posedge clk) quad <= 2'h2;
    go(2);
    expf("quad", 16'h0080, 16'h0000);
    @(posedge clk) step <= 1'h1;
    repeat (256) @(posedge clk);
    step <= 1'h0;
    go(1);
    chk("turns", 24'h000100, {14'h0, tcnt});
    chk("tov_no", 24'h0, {8'h00, warn});
    @(posedge clk) step <= 1'h1;
    @(posedge clk) step <= 1'h0;
    #1 chk("turns_sat", 24'h000100, {14'h0, tcnt});
    expf("tov", 16'h0000, 16'h0008);
    @(posedge clk) tclr <= 1'h1;
    @(posedge clk) tclr <= 1'h0;
    #1 chk("turns_clr", 24'h0, {14'h0, tcnt});
    @(posedge clk) step <= 1'h1;
    tup <= 1'h0;
    repeat (257) @(posedge clk);
    step <= 1'h0;
    go(1);
    chk("turns_dn", 24'hFFFF00, {{14{tcnt[9]}}, tcnt});
    expf("tov_dn", 16'h0000, 16'h0008);
    @(posedge clk) slp <= 1'h1;
    wk(12'h000, 1'h0);
    wk(12'h7D0, 1'h1);
    expf("jump", 16'h0000, 16'h0010);
    wk(12'h7DA, 1'h0);
    wk(12'hA79, 1'h0);
    wk(12'hD19, 1'h1);
    chk("pos_ang", 24'h000D19, {12'h000, pos[11:0]});
    expf("nojump", 16'h0000, 16'h0000);
    @(posedge clk) slp <= 1'h0;
    go(2);
    chk("stay_off", 24'h0, {23'h0, stay});
    avp(2);
    chk("avg2", 24'h0, {8'h00, err});
    avp(3);
    expf("avg", 16'h0200, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk) fr <= '{1'h1, 6'(fc[i]), fb[i][3], fb[i][1]};
      flong <= fb[i][2];
      crc_en <= fb[i][0];
      @(posedge clk) fr.done <= 1'h0;
      #1 expf("frm", 16'h0000, 16'(fw[i]));
    end
    test_done();
  end
endmodule
`default_nettype wire
